// ---- common/aopm_map.svh ----
`ifndef AOPM_MAP_SVH
`define AOPM_MAP_SVH
// result word width and pad count of the shared output bus
`define AOPM_RES_W 14
// shared pad positions used by the serial modes
`define AOPM_PAD_DIV_LO 0
`define AOPM_PAD_DIV_HI 1
`define AOPM_PAD_CLK_SRC 2
`define AOPM_PAD_SYNC_POL 3
`define AOPM_PAD_CLK_INV 4
`define AOPM_PAD_RD_MODE 5
`define AOPM_PAD_SER_OUT 6
`define AOPM_PAD_SER_CLK 7
`define AOPM_PAD_SYNC 8
// positions inside the synchronised strap vector
`define AOPM_CTL_W 4
`define AOPM_CTL_SERIAL_PARALLEL_SELECT 0
`define AOPM_CTL_IMPULSE 1
`define AOPM_CTL_WARP 2
`define AOPM_CTL_CS_N 3
// reset values
`define AOPM_RST_PADS 14'h0000
`define AOPM_RST_CTL 4'h8
`define AOPM_RST_BITCNT 4'h0
// last bit index of a frame and divider limits per code
`define AOPM_LAST_BIT 4'hd
`define AOPM_DIV_LIM0 3'h0
`define AOPM_DIV_LIM1 3'h1
`define AOPM_DIV_LIM2 3'h3
`define AOPM_DIV_LIM3 3'h7
`endif

// ---- common/aopm_pkg.sv ----
package aopm_pkg;
  // conversion mode decoded from the two strap inputs
  typedef enum logic [1:0] {
    AOPM_MODE_NORMAL,
    AOPM_MODE_IMPULSE,
    AOPM_MODE_WARP
  } aopm_mode_e;
  // master frame sequencer
  typedef enum logic [1:0] {
    AOPM_ST_IDLE,
    AOPM_ST_SHIFT
  } aopm_state_e;
  // status carried out of the block together
  typedef struct packed {
    logic serial;
    logic master;
    logic read_after;
    logic frame;
    aopm_mode_e mode;
  } aopm_status_s;
endpackage

// ---- hdl/aopm_clk_div.sv ----
`timescale 1ns/1ps
`include "aopm_map.svh"
// tick generator that paces the internal serial clock
module aopm_clk_div
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic [1:0] code_i,
  output logic tick_o
);
  logic [2:0] cnt_ff; // cycles since last tick
  logic [2:0] nxt_cnt;
  logic nxt_tick;
  logic [2:0] limit; // cycles between ticks minus one
  logic at_limit;

  // code zero means undivided: a tick on every cycle
  assign limit = (code_i == 2'h0) ? `AOPM_DIV_LIM0 :
                 (code_i == 2'h1) ? `AOPM_DIV_LIM1 :
                 (code_i == 2'h2) ? `AOPM_DIV_LIM2 : `AOPM_DIV_LIM3; // RULE13
  assign at_limit = (cnt_ff >= limit);
  assign nxt_cnt = (!run_i || at_limit) ? 3'h0 : cnt_ff + 3'h1;
  assign nxt_tick = run_i && at_limit;

  // counter restarts whenever no frame runs so every frame starts in phase
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      cnt_ff <= 3'h0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_o <= nxt_tick;
    end
  end
endmodule // aopm_clk_div

// ---- hdl/aopm_top.sv ----
`timescale 1ns/1ps
`include "aopm_map.svh"
// What this block does
// RULE1: parallel select low drives result on bus
// RULE2: serial mode: serial pins only, rest high-impedance
// RULE3: parallel: pads 0,1 carry result bits 0,1
// RULE4: master read-after: divider pins slow internal clock
// RULE5: other serial modes: divider pins hi-z, ignored
// RULE6: parallel: clock-source pad carries result bit 2
// RULE7: serial master: internal clock driven on clock pin
// RULE8: serial slave: shift data on host clock
// RULE9: parallel: sync-polarity pad carries result bit 3
// RULE10: master sync high when polarity low, else low
// RULE11: decode normal, impulse, warp from two straps
// RULE12: sync active while serial data valid
// RULE13: divider code picks four rates, zero undivided
module aopm_top
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic serial_parallel_select_i, // strap pin, high selects serial
  input wire logic warp_select_i, // strap pin
  input wire logic impulse_select_i, // strap pin
  input wire logic chip_select_n_i, // pin, active low
  input wire logic [`AOPM_RES_W-1:0] result_i, // conversion result, same clock
  input wire logic result_valid_i, // one-cycle pulse with a new result
  input wire logic [`AOPM_RES_W-1:0] pad_in_i, // levels seen on the data pads
  output logic [`AOPM_RES_W-1:0] pad_out_o, // value driven on the data pads
  output logic [`AOPM_RES_W-1:0] pad_oe_o, // high where the pad is driven
  output aopm_pkg::aopm_status_s status_o // decoded mode and frame status
);
  import aopm_pkg::*;

  // two-stage synchronisers for every pin input
  logic [`AOPM_RES_W-1:0] pad_s1_ff;
  logic [`AOPM_RES_W-1:0] pad_s2_ff;
  logic [`AOPM_CTL_W-1:0] ctl_s1_ff;
  logic [`AOPM_CTL_W-1:0] ctl_s2_ff;
  logic [`AOPM_CTL_W-1:0] ctl_raw;
  // edge history for host clock and chip select
  logic sclk_prev_ff;
  logic cs_n_prev_ff;
  // data path
  logic [`AOPM_RES_W-1:0] result_ff; // last result, feeds parallel bus and slave reads
  logic [`AOPM_RES_W-1:0] shift_ff; // serial shifter, msb first
  logic [`AOPM_RES_W-1:0] nxt_shift;
  logic [3:0] bit_cnt_ff; // bits still to send after the current one
  logic [3:0] nxt_bit_cnt;
  logic sclk_ff; // internal serial clock level
  logic nxt_sclk;
  aopm_state_e state_ff;
  aopm_state_e nxt_state;
  logic [`AOPM_RES_W-1:0] nxt_pad_out;
  logic [`AOPM_RES_W-1:0] nxt_pad_oe;
  aopm_status_s nxt_status;

  // decoded configuration
  logic serial;
  logic master;
  logic slave;
  logic read_after;
  logic [1:0] div_code;
  logic tick;
  logic sync_pol;
  logic clk_inv;
  logic sclk_in;
  logic slave_edge;
  logic cs_fall;
  logic cs_low;
  logic frame;
  logic sync_level;
  logic start;
  aopm_mode_e mode;

  assign ctl_raw[`AOPM_CTL_SERIAL_PARALLEL_SELECT] = serial_parallel_select_i;
  assign ctl_raw[`AOPM_CTL_IMPULSE] = impulse_select_i;
  assign ctl_raw[`AOPM_CTL_WARP] = warp_select_i;
  assign ctl_raw[`AOPM_CTL_CS_N] = chip_select_n_i;

  // pads and straps come from outside this clock, so two flops before use
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      pad_s1_ff <= `AOPM_RST_PADS;
      pad_s2_ff <= `AOPM_RST_PADS;
      ctl_s1_ff <= `AOPM_RST_CTL;
      ctl_s2_ff <= `AOPM_RST_CTL;
    end
    else
    begin
      pad_s1_ff <= pad_in_i;
      pad_s2_ff <= pad_s1_ff;
      ctl_s1_ff <= ctl_raw;
      ctl_s2_ff <= ctl_s1_ff;
    end
  end

  // mode decode; the clock-source and polarity straps only mean something in serial
  assign serial = ctl_s2_ff[`AOPM_CTL_SERIAL_PARALLEL_SELECT];
  assign master = serial && !pad_s2_ff[`AOPM_PAD_CLK_SRC]; // RULE7
  assign slave = serial && pad_s2_ff[`AOPM_PAD_CLK_SRC]; // RULE8
  assign read_after = master && !pad_s2_ff[`AOPM_PAD_RD_MODE];
  // divider pads are only looked at in master read-after mode
  assign div_code = read_after ?
                    {pad_s2_ff[`AOPM_PAD_DIV_HI], pad_s2_ff[`AOPM_PAD_DIV_LO]} :
                    2'h0; // RULE4 RULE5
  assign sync_pol = pad_s2_ff[`AOPM_PAD_SYNC_POL];
  assign clk_inv = pad_s2_ff[`AOPM_PAD_CLK_INV];

  // both-equal straps give normal, lone impulse or lone warp selects that mode
  assign mode = (ctl_s2_ff[`AOPM_CTL_IMPULSE] == ctl_s2_ff[`AOPM_CTL_WARP]) ?
                AOPM_MODE_NORMAL :
                (ctl_s2_ff[`AOPM_CTL_IMPULSE] ? AOPM_MODE_IMPULSE : AOPM_MODE_WARP); // RULE11

  // host clock and chip select edges, seen after the synchroniser
  assign sclk_in = pad_s2_ff[`AOPM_PAD_SER_CLK];
  assign cs_low = !ctl_s2_ff[`AOPM_CTL_CS_N];
  assign cs_fall = cs_n_prev_ff && !ctl_s2_ff[`AOPM_CTL_CS_N];
  // the host clock must be slow against clk_sys: the synchroniser costs two cycles
  assign slave_edge = clk_inv ? (sclk_prev_ff && !sclk_in) :
                      (!sclk_prev_ff && sclk_in); // RULE8

  assign frame = (state_ff == AOPM_ST_SHIFT);
  assign start = master && result_valid_i && (state_ff == AOPM_ST_IDLE);
  // sync follows the frame, inverted when the polarity strap is high
  assign sync_level = frame ^ sync_pol; // RULE10 RULE12

  aopm_clk_div u_clk_div
  (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .run_i(frame),
    .code_i(div_code),
    .tick_o(tick)
  );

  // master sequencer and shared shifter; master data moves on the falling internal edge, slave data on the active host edge
  always_comb
  begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_sclk = sclk_ff;
    case (state_ff)
      AOPM_ST_IDLE:
      begin
        nxt_sclk = 1'b0;
        if (start)
        begin
          // new result loads straight from the converter output
          nxt_shift = result_i; // RULE7
          nxt_bit_cnt = `AOPM_LAST_BIT;
          nxt_state = AOPM_ST_SHIFT;
        end
        else if (slave && cs_fall)
        begin
          // host begins a read: first bit is on the pad right after select
          nxt_shift = result_ff; // RULE8
        end
        else if (slave && cs_low && slave_edge)
        begin
          nxt_shift = {shift_ff[`AOPM_RES_W-2:0], 1'b0}; // RULE8
        end
      end
      AOPM_ST_SHIFT:
      begin
        if (!master)
        begin
          // strap changed mid frame: abandon it rather than emit garbage
          nxt_state = AOPM_ST_IDLE;
          nxt_sclk = 1'b0;
        end
        else if (tick)
        begin
          nxt_sclk = !sclk_ff; // RULE7 RULE4
          if (sclk_ff)
          begin
            if (bit_cnt_ff == 4'h0)
            begin
              nxt_state = AOPM_ST_IDLE;
            end
            else
            begin
              nxt_shift = {shift_ff[`AOPM_RES_W-2:0], 1'b0};
              nxt_bit_cnt = bit_cnt_ff - 4'h1;
            end
          end
        end
      end
      default:
      begin
        nxt_state = AOPM_ST_IDLE;
        nxt_sclk = 1'b0;
      end
    endcase
  end

  // pad drive: full result in parallel, only the serial pads otherwise
  always_comb
  begin
    nxt_pad_out = `AOPM_RST_PADS;
    nxt_pad_oe = `AOPM_RST_PADS;
    if (!serial)
    begin
      // pad i carries result bit i, including the shared strap pads
      nxt_pad_out = result_ff; // RULE1 RULE3 RULE6 RULE9
      nxt_pad_oe = {`AOPM_RES_W{1'b1}}; // RULE1
    end
    else
    begin
      // every other pad stays undriven in serial mode
      nxt_pad_out[`AOPM_PAD_SER_OUT] = shift_ff[`AOPM_RES_W-1];
      nxt_pad_oe[`AOPM_PAD_SER_OUT] = 1'b1; // RULE2
      nxt_pad_out[`AOPM_PAD_SER_CLK] = sclk_ff;
      nxt_pad_oe[`AOPM_PAD_SER_CLK] = master; // RULE7
      nxt_pad_out[`AOPM_PAD_SYNC] = sync_level;
      nxt_pad_oe[`AOPM_PAD_SYNC] = master; // RULE10
    end
  end

  assign nxt_status.serial = serial;
  assign nxt_status.master = master;
  assign nxt_status.read_after = read_after;
  assign nxt_status.frame = frame;
  assign nxt_status.mode = mode;

  // state, result hold and edge history
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      state_ff <= AOPM_ST_IDLE;
      shift_ff <= `AOPM_RST_PADS;
      bit_cnt_ff <= `AOPM_RST_BITCNT;
      sclk_ff <= 1'b0;
      result_ff <= `AOPM_RST_PADS;
      sclk_prev_ff <= 1'b0;
      cs_n_prev_ff <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      bit_cnt_ff <= nxt_bit_cnt;
      sclk_ff <= nxt_sclk;
      result_ff <= result_valid_i ? result_i : result_ff;
      sclk_prev_ff <= sclk_in;
      cs_n_prev_ff <= ctl_s2_ff[`AOPM_CTL_CS_N];
    end
  end

  // outputs straight from flops; all pads released during reset
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      pad_out_o <= `AOPM_RST_PADS;
      pad_oe_o <= `AOPM_RST_PADS;
      status_o <= '0;
    end
    else
    begin
      pad_out_o <= nxt_pad_out;
      pad_oe_o <= nxt_pad_oe;
      status_o <= nxt_status;
    end
  end
endmodule // aopm_top

// ---- tb/aopm_host_model.sv ----
`timescale 1ns/1ps
// host side: gated clock and chip select for slave reads, capture in master
module aopm_host_model
(
  input wire logic clk_sys_i,
  input wire logic [13:0] pad_out_i, // levels seen on the data pads
  input wire logic inv_i, // high makes the falling host edge active
  output logic cs_n_o, // chip select, active low
  output logic sclk_o // host clock, still outside reads
);
  initial cs_n_o = 1'b1;
  initial sclk_o = 1'b0;
  // slow host clock, far under the block's sampling limit
  task automatic read_slave(output logic [13:0] w);
    sclk_o = inv_i;
    cs_n_o = 1'b0;
    for (int i = 13; i >= 0; i--)
    begin
      repeat (12) @(negedge clk_sys_i);
      w[i] = pad_out_i[6];
      sclk_o = ~inv_i;
      repeat (12) @(negedge clk_sys_i);
      sclk_o = inv_i;
    end
    cs_n_o = 1'b1;
  endtask
  // master: a bit is taken at each rise of the block's clock
  task automatic read_master(output logic [13:0] w, output int hi);
    logic prev;
    int n;
    prev = 1'b0;
    n = 14;
    hi = 0;
    for (int c = 0; c < 4000 && n > 0; c++)
    begin
      @(negedge clk_sys_i);
      if (pad_out_i[7] && !prev)
      begin
        n--;
        w[n] = pad_out_i[6];
      end
      hi += int'(pad_out_i[7]);
      prev = pad_out_i[7];
    end
  endtask
endmodule // aopm_host_model

// ---- tb/aopm_top_chk.sv ----
`timescale 1ns/1ps
`include "aopm_map.svh"
// port checks of the output port block
module aopm_top_chk
  import aopm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic serial_parallel_select_i,
  input wire logic warp_select_i,
  input wire logic impulse_select_i,
  input wire logic chip_select_n_i,
  input wire logic [`AOPM_RES_W-1:0] result_i,
  input wire logic result_valid_i,
  input wire logic [`AOPM_RES_W-1:0] pad_in_i,
  input wire logic [`AOPM_RES_W-1:0] pad_out_o,
  input wire logic [`AOPM_RES_W-1:0] pad_oe_o,
  input wire aopm_pkg::aopm_status_s status_o
);
  logic [2:0] age_ff; // edges since reset, stops at 7
  logic [2:0] cs_hi_ff; // consecutive edges with chip select high, cleared while it is low, stops at 7
  // guards keep the strap sync latency out of the checks
  wire logic ok = age_ff == 3'h7;
  wire logic mst = status_o.serial && status_o.master;
  wire logic slv = status_o.serial && !status_o.master;
  wire logic [2:0] nxt_age = ok ? age_ff : age_ff + 3'h1;
  wire logic [2:0] nxt_cs_hi = chip_select_n_i ? cs_hi_ff + {2'h0, cs_hi_ff != 3'h7} : 3'h0;
  always_ff @(posedge clk_sys_i)
  begin
    age_ff <= reset_i ? 3'h0 : nxt_age;
    cs_hi_ff <= reset_i ? 3'h0 : nxt_cs_hi;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  property p_par_oe;
    ok && !status_o.serial |-> pad_oe_o == 14'h3fff;
  endproperty
  a_par_oe: assert property (p_par_oe) else $error("parallel enable");
  property p_par_dat;
    ok && !status_o.serial && !$past(status_o.serial, 2) && $past(result_valid_i, 2)
      |-> pad_out_o == $past(result_i, 2);
  endproperty
  a_par_dat: assert property (p_par_dat) else $error("parallel data");
  property p_ser_hiz;
    status_o.serial |-> (pad_oe_o & 14'h3e3f) == 14'h0000;
  endproperty
  a_ser_hiz: assert property (p_ser_hiz) else $error("serial hi-z");
  property p_clk_pin;
    status_o.serial |-> pad_oe_o[7] == status_o.master;
  endproperty
  a_clk_pin: assert property (p_clk_pin) else $error("clock pin drive");
  property p_mode;
    ok && $past(warp_select_i, 4) == warp_select_i &&
      $past(impulse_select_i, 4) == impulse_select_i
      |-> status_o.mode == (warp_select_i == impulse_select_i ? AOPM_MODE_NORMAL :
      warp_select_i ? AOPM_MODE_WARP : AOPM_MODE_IMPULSE);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode");
  property p_sync;
    ok && mst && $past(mst, 4) && $stable(status_o.frame) && $past(pad_in_i[3], 4) ==
      pad_in_i[3] |-> pad_out_o[8] == (status_o.frame ^ pad_in_i[3]);
  endproperty
  a_sync: assert property (p_sync) else $error("sync level");
  property p_frame;
    ok && $fell(status_o.frame) |-> $past(status_o.frame, 26);
  endproperty
  a_frame: assert property (p_frame) else $error("frame short");
  property p_slave;
    ok && slv && $past(slv, 5) && cs_hi_ff == 3'h7 |-> $stable(pad_out_o[6]);
  endproperty
  a_slave: assert property (p_slave) else $error("slave shift");
endmodule // aopm_top_chk
bind aopm_top aopm_top_chk u_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
  .serial_parallel_select_i(serial_parallel_select_i), .warp_select_i(warp_select_i),
  .impulse_select_i(impulse_select_i), .chip_select_n_i(chip_select_n_i),
  .result_i(result_i), .result_valid_i(result_valid_i), .pad_in_i(pad_in_i),
  .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .status_o(status_o));

// ---- tb/test_aopm_top.sv ----
`timescale 1ns/1ps
`include "aopm_map.svh"
// queue model against the output port block
module test_aopm_top;
  import aopm_pkg::*;
  logic clk = 1'b0; // 10 MHz
  logic rst = 1'b1;
  logic ser = 1'b0;
  logic warp = 1'b0;
  logic imp = 1'b0;
  logic vld = 1'b0;
  logic [13:0] res = 14'h0000;
  logic [13:0] strap = 14'h0000; // far side levels on the pads
  logic cs_n;
  logic sclk;
  logic [13:0] pout;
  logic [13:0] poe;
  aopm_status_s st;
  logic [13:0] q [$]; // results owed to the bus
  int hw [4]; // clock high cycles per divider code
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  // wire level: block drive where enabled, far side elsewhere
  // an undriven data-out pad reads inverted, so a lost enable cannot pass unseen
  wire logic [13:0] pin = (poe & pout) | (~poe & {strap[13:8], sclk, ~pout[6], strap[5:0]});
  always #50 clk = ~clk;
  aopm_top u_aopm_top (.clk_sys_i(clk), .reset_i(rst), .serial_parallel_select_i(ser),
    .warp_select_i(warp), .impulse_select_i(imp), .chip_select_n_i(cs_n), .result_i(res),
    .result_valid_i(vld), .pad_in_i(pin), .pad_out_o(pout), .pad_oe_o(poe), .status_o(st));
  aopm_host_model u_aopm_host_model (.clk_sys_i(clk), .pad_out_i(pin), .inv_i(strap[4]),
    .cs_n_o(cs_n), .sclk_o(sclk));
  task automatic tally_and_finish;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bad(input string m);
    miscompares++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic cmp_word(input logic [13:0] got, input logic [13:0] exp);
    n_compared++;
    if (got !== exp)
      bad("word differs");
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
      bad("flag differs");
  endtask
  // straps change at a falling edge, then settle through the syncs
  task automatic setm(input logic s, input logic [5:0] st6);
    @(negedge clk);
    ser = s;
    strap = {8'h00, st6};
    repeat (8) @(negedge clk);
  endtask
  task automatic pulse(output logic [13:0] r);
    r = 14'($urandom);
    @(negedge clk);
    res = r;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
  endtask
  task automatic run_master(input logic [5:0] st6, output int hi);
    logic [13:0] r;
    logic [13:0] w;
    setm(1'b1, st6);
    cmp_flag(st.serial, 1'b1);
    cmp_flag(st.master, 1'b1);
    cmp_flag(st.read_after, ~st6[5]);
    pulse(r);
    u_aopm_host_model.read_master(w, hi);
    cmp_word(w, r);
    cmp_flag(pin[8], ~st6[3]);
    for (int k = 0; k < 300 && st.frame !== 1'b0; k++)
      @(negedge clk);
    repeat (3) @(negedge clk);
    cmp_flag(st.frame, 1'b0);
    cmp_flag(pin[8], st6[3]);
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad("timeout");
      tally_and_finish();
    end
  end
  initial
  begin
    logic [13:0] r;
    logic [13:0] w;
    int hi;
    void'($urandom(32'h0817));
    repeat (16) @(negedge clk);
    rst = 1'b0;
    setm(1'b0, 6'h00);
    for (int i = 0; i < 12; i++)
    begin
      @(negedge clk);
      // a result taken at one edge stands on the pads from two edges later
      if (i >= 2)
      begin
        cmp_word(pout, q[0]);
        if (q.size() > 1)
          void'(q.pop_front());
      end
      vld = (i < 8);
      res = 14'($urandom);
      if (i < 8)
        q.push_back(res);
    end
    cmp_word(poe, 14'h3fff);
    cmp_flag(st.serial, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      {warp, imp} = 2'(k);
      repeat (7) @(negedge clk);
      cmp_flag(st.mode == (k == 1 ? AOPM_MODE_IMPULSE : k == 2 ? AOPM_MODE_WARP :
        AOPM_MODE_NORMAL), 1'b1);
    end
    $display("test parallel and mode done");
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 4; c++)
      begin
        run_master({2'b00, 1'(p), 1'b0, 2'(c)}, hi);
        if (p == 0)
          hw[c] = hi;
      end
    for (int c = 1; c < 4; c++)
      cmp_flag(hw[c] > hw[c - 1], 1'b1);
    run_master(6'h23, hi);
    cmp_flag(hi == hw[0], 1'b1);
    $display("test master done");
    for (int v = 0; v < 2; v++)
    begin
      setm(1'b1, {1'b0, 1'(v), 4'h4});
      cmp_flag(st.master, 1'b0);
      pulse(r);
      u_aopm_host_model.read_slave(w);
      cmp_word(w, r);
    end
    $display("test slave done");
    tally_and_finish();
  end
endmodule // test_aopm_top
